// ### design/wmu_mult.sv
// Package of shared constants and types, plus the 16x16 multiplier core
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Shared package
// ----------------------------------------------------------------------------
package wmu_pkg;
   // Register map, byte addresses on the slave port
   localparam int WMU_ADDR_W = 10;
   localparam logic [9:0] OFS_CORE_CTRL = 10'h000;
   localparam logic [9:0] OFS_STATUS = 10'h004;
   localparam logic [9:0] OFS_INSTR = 10'h008;
   localparam logic [9:0] OFS_FLAGS = 10'h00C;
   localparam logic [9:0] OFS_ACCUMULATOR_A_LO = 10'h010;
   localparam logic [9:0] OFS_ACCUMULATOR_A_HI = 10'h014;
   localparam logic [9:0] OFS_ACCUMULATOR_A_UP = 10'h018;
   localparam logic [9:0] OFS_ACCUMULATOR_B_LO = 10'h01C;
   localparam logic [9:0] OFS_ACCUMULATOR_B_HI = 10'h020;
   localparam logic [9:0] OFS_ACCUMULATOR_B_UP = 10'h024;
   localparam logic [9:0] OFS_WREG_BASE = 10'h040;
   localparam logic [9:0] OFS_WREG_END = 10'h080;
   localparam logic [9:0] OFS_DMEM_BASE = 10'h080;
   // Values after reset
   localparam logic [15:0] CORE_CTRL_RESET = 16'h0001;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] WREG_RESET = 16'h0000;
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
   // Field positions
   localparam int CTRL_INT_BIT = 0;
   localparam int CTRL_SIGN_LSB = 1;
   localparam int FLAG_BUSY_BIT = 0;
   localparam int FLAG_ILLEGAL_BIT = 1;
   // Opcode bytes and field values
   localparam logic [7:0] OPC_GRP_B8 = 8'hB8;
   localparam logic [7:0] OPC_GRP_B9 = 8'hB9;
   localparam logic [2:0] ACC_FORM_D = 3'h7;
   localparam logic [1:0] LIT_FORM_P = 2'h3;
   localparam logic [3:0] DEST_MAX = 4'hC;
   localparam logic [15:0] ADDR_STEP = 16'h0002;
   // Source addressing modes
   localparam logic [2:0] AM_DIRECT = 3'h0;
   localparam logic [2:0] AM_INDIRECT = 3'h1;
   localparam logic [2:0] AM_POST_DEC = 3'h2;
   localparam logic [2:0] AM_POST_INC = 3'h3;
   localparam logic [2:0] AM_PRE_DEC = 3'h4;
   localparam logic [2:0] AM_PRE_INC = 3'h5;

   // Decoded multiply instruction
   typedef struct packed {
      logic [3:0] base;
      logic [3:0] src;
      logic [3:0] dst;
      logic [2:0] mode;
      logic [4:0] lit;
      logic use_lit;
      logic acc_b;
      logic to_acc;
      logic a_signed;
      logic b_signed;
      logic illegal;
   } wmu_op_t;

   // Instruction word decode; word-only, no byte variant exists
   function automatic wmu_op_t wmu_decode(input logic [23:0] iw);
      wmu_op_t op;
      logic acc_form;
      logic ss;
      logic su;
      logic us;
      logic word;
      logic lit_form;
      op = '0;
      acc_form = (iw[23:16] == OPC_GRP_B8) && !iw[15] && (iw[10:8] == ACC_FORM_D) && (iw[6:5] == LIT_FORM_P);
      ss = (iw[23:16] == OPC_GRP_B9) && iw[15];
      su = (iw[23:16] == OPC_GRP_B9) && !iw[15];
      us = (iw[23:16] == OPC_GRP_B8) && iw[15];
      word = ss || su || us;
      lit_form = acc_form || (su && (iw[6:5] == LIT_FORM_P));
      op.base = iw[14:11];
      op.src = iw[3:0];
      op.dst = iw[10:7];
      op.mode = iw[6:4];
      op.lit = iw[4:0];
      op.use_lit = lit_form;
      op.acc_b = iw[7];
      op.to_acc = acc_form;
      op.a_signed = ss || su;
      op.b_signed = ss || us;
      op.illegal = !(acc_form || word) || (word && (iw[7] || (iw[10:7] > DEST_MAX)))
                   || (!lit_form && (iw[6:4] > AM_PRE_INC));
      return op;
   endfunction : wmu_decode
endpackage : wmu_pkg

// ----------------------------------------------------------------------------
// Multiplier core with per-operand signedness
// ----------------------------------------------------------------------------
module wmu_mult #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] op_a,
   input wire logic [WIDTH-1:0] op_b,
   input wire logic a_signed,
   input wire logic b_signed,
   output logic [2*WIDTH-1:0] product
);
   logic signed [WIDTH:0] ext_a;
   logic signed [WIDTH:0] ext_b;
   logic signed [2*WIDTH+1:0] full;

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("wmu_mult: WIDTH must be at least 2");
      end
   endgenerate

   // Sign or zero extension by one bit, then one signed product
   assign ext_a = {a_signed & op_a[WIDTH-1], op_a};
   assign ext_b = {b_signed & op_b[WIDTH-1], op_b};
   assign full = ext_a * ext_b;
   assign product = full[2*WIDTH-1:0];
endmodule : wmu_mult

`default_nettype wire

// ### design/wmu_top.sv
// Word multiply unit: register file, decode, operand fetch and result write
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Literal multiply: 32-bit product into accumulator
// - Accumulator bits 39 down to 32 zero
// - Literal multiply operands are both unsigned
// - Integer/fraction bit selects product scaling
// - Sign mode field ignored by literal multiply
// - Fields: k literal, w base, A accumulator
// - Word operation only, no byte form
// - Word destination even register 0 to 12
// - Register 14 never a destination
// - Source direct or indirect, with pointer updates
// - Fields: d destination, p mode, s source
module wmu_top #(
   parameter int DMEM_DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [wmu_pkg::WMU_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import wmu_pkg::*;

   localparam int IDX_W = $clog2(DMEM_DEPTH);
   localparam int DMEM_SPAN = 4 * DMEM_DEPTH;

   generate
      if ((DMEM_DEPTH < 2) || ((1 << IDX_W) != DMEM_DEPTH) || (int'(OFS_DMEM_BASE) + DMEM_SPAN > 1024)) begin : g_bad
         $error("wmu_top: DMEM_DEPTH must be a power of two from 2 to 224 words");
      end
   endgenerate

   typedef enum logic {ST_IDLE, ST_EXEC} wmu_state_t;

   // ----------------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic rst_s_n;

   // Two stage release of the asynchronous reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_s_n = rst_pipe[1];

   // ----------------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------------
   logic [15:0] core_control_reg;
   logic [15:0] status_reg;
   logic [23:0] instr_word;
   logic illegal_flag;
   logic [39:0] accumulator_a;
   logic [39:0] accumulator_b;
   logic [15:0] wreg [16];
   logic [15:0] dmem [DMEM_DEPTH];
   wmu_state_t state;
   wmu_op_t op;

   // Byte lane merge for 16-bit registers
   function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic [1:0] be);
      return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : merge_lanes

   // ----------------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------------
   logic busy;
   logic accept;
   logic wr_fire;
   logic hit_wreg;
   logic hit_dmem;
   logic [3:0] bus_wreg_idx;
   logic [IDX_W-1:0] bus_dmem_idx;
   logic [WMU_ADDR_W-1:0] dmem_end;
   logic launch;
   logic [31:0] next_readdata;

   assign busy = (state != ST_IDLE);
   assign accept = (avs_read || avs_write) && avs_waitrequest && !busy;
   assign wr_fire = avs_write && !avs_waitrequest;
   assign dmem_end = WMU_ADDR_W'(int'(OFS_DMEM_BASE) + DMEM_SPAN);
   assign hit_wreg = (avs_address >= OFS_WREG_BASE) && (avs_address < OFS_WREG_END) && (avs_address[1:0] == 2'h0);
   assign hit_dmem = (avs_address >= OFS_DMEM_BASE) && (avs_address < dmem_end) && (avs_address[1:0] == 2'h0);
   assign bus_wreg_idx = avs_address[5:2];
   assign bus_dmem_idx = avs_address[IDX_W+1:2];
   assign launch = wr_fire && (avs_address == OFS_INSTR) && (avs_byteenable[2:0] == 3'h7);

   // Read selection; unmapped addresses read zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_address == OFS_CORE_CTRL) begin
         next_readdata = {16'h0000, core_control_reg};
      end else if (avs_address == OFS_STATUS) begin
         next_readdata = {16'h0000, status_reg};
      end else if (avs_address == OFS_INSTR) begin
         next_readdata = {8'h00, instr_word};
      end else if (avs_address == OFS_FLAGS) begin
         next_readdata = {30'h0000_0000, illegal_flag, busy};
      end else if (avs_address == OFS_ACCUMULATOR_A_LO) begin
         next_readdata = {16'h0000, accumulator_a[15:0]};
      end else if (avs_address == OFS_ACCUMULATOR_A_HI) begin
         next_readdata = {16'h0000, accumulator_a[31:16]};
      end else if (avs_address == OFS_ACCUMULATOR_A_UP) begin
         next_readdata = {24'h00_0000, accumulator_a[39:32]};
      end else if (avs_address == OFS_ACCUMULATOR_B_LO) begin
         next_readdata = {16'h0000, accumulator_b[15:0]};
      end else if (avs_address == OFS_ACCUMULATOR_B_HI) begin
         next_readdata = {16'h0000, accumulator_b[31:16]};
      end else if (avs_address == OFS_ACCUMULATOR_B_UP) begin
         next_readdata = {24'h00_0000, accumulator_b[39:32]};
      end else if (hit_wreg) begin
         next_readdata = {16'h0000, wreg[bus_wreg_idx]};
      end else if (hit_dmem) begin
         next_readdata = {16'h0000, dmem[bus_dmem_idx]};
      end
   end

   // One wait cycle, then a one-cycle answer; held off while executing
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !accept;
         if (accept && avs_read) begin
            avs_readdata <= next_readdata;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Execution datapath
   // ----------------------------------------------------------------------------
   logic exec;
   logic [15:0] src_ptr;
   logic [15:0] eff_addr;
   logic [15:0] src_val;
   logic [15:0] mul_b;
   logic [31:0] product;
   logic [39:0] acc_val;
   logic ptr_upd;
   logic [15:0] next_ptr;
   logic word_wb;

   assign exec = (state == ST_EXEC);
   assign src_ptr = wreg[op.src];
   // Pre-modified forms address the updated pointer
   assign eff_addr = (op.mode == AM_PRE_DEC) ? src_ptr - ADDR_STEP :
                     (op.mode == AM_PRE_INC) ? src_ptr + ADDR_STEP : src_ptr;
   assign src_val = (op.mode == AM_DIRECT) ? src_ptr : dmem[eff_addr[IDX_W:1]];
   assign mul_b = op.use_lit ? {11'h000, op.lit} : src_val;
   assign ptr_upd = !op.use_lit && (op.mode >= AM_POST_DEC);
   assign next_ptr = ((op.mode == AM_POST_DEC) || (op.mode == AM_PRE_DEC)) ? src_ptr - ADDR_STEP
                                                                            : src_ptr + ADDR_STEP;
   assign word_wb = exec && !op.illegal && !op.to_acc;
   // Fraction mode shifts the product one place; bits above stay zero
   assign acc_val = core_control_reg[CTRL_INT_BIT] ? {8'h00, product} : {7'h00, product, 1'b0};

   // Signedness from the decoded form only; sign mode bits never used
   wmu_mult #(
      .WIDTH(16)
   ) u_mult (
      .op_a(wreg[op.base]),
      .op_b(mul_b),
      .a_signed(op.a_signed),
      .b_signed(op.b_signed),
      .product(product)
   );

   // Instruction sequencing: decode at launch, execute next cycle
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state <= ST_IDLE;
         op <= '0;
         instr_word <= 24'h00_0000;
      end else if (launch) begin
         state <= ST_EXEC;
         op <= wmu_decode(avs_writedata[23:0]);
         instr_word <= avs_writedata[23:0];
      end else begin
         state <= ST_IDLE;
      end
   end

   // Accumulator load, A or B
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         accumulator_a <= ACC_RESET;
         accumulator_b <= ACC_RESET;
      end else if (exec && op.to_acc && !op.illegal) begin
         if (op.acc_b) begin
            accumulator_b <= acc_val;
         end else begin
            accumulator_a <= acc_val;
         end
      end
   end

   // Working registers: bus write, pointer update, then result word
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         for (int i = 0; i < 16; i++) begin
            wreg[i] <= WREG_RESET;
         end
      end else begin
         if (wr_fire && hit_wreg) begin
            wreg[bus_wreg_idx] <= merge_lanes(wreg[bus_wreg_idx], avs_writedata[15:0], avs_byteenable[1:0]);
         end
         if (exec && !op.illegal && ptr_upd) begin
            wreg[op.src] <= next_ptr;
         end
         if (word_wb) begin
            wreg[op.dst] <= product[15:0];
         end
      end
   end

   // Operand data memory, written by software only
   always_ff @(posedge mclk) begin
      if (wr_fire && hit_dmem) begin
         dmem[bus_dmem_idx] <= merge_lanes(dmem[bus_dmem_idx], avs_writedata[15:0], avs_byteenable[1:0]);
      end
   end

   // Control, status and the sticky bad-instruction flag; set wins over clear
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         core_control_reg <= CORE_CTRL_RESET;
         status_reg <= STATUS_RESET;
         illegal_flag <= 1'b0;
      end else begin
         if (wr_fire && (avs_address == OFS_CORE_CTRL)) begin
            core_control_reg <= merge_lanes(core_control_reg, avs_writedata[15:0], avs_byteenable[1:0]);
         end
         if (wr_fire && (avs_address == OFS_STATUS)) begin
            status_reg <= merge_lanes(status_reg, avs_writedata[15:0], avs_byteenable[1:0]);
         end
         if (exec && op.illegal) begin
            illegal_flag <= 1'b1;
         end else if (wr_fire && (avs_address == OFS_FLAGS) && avs_byteenable[0]
                      && avs_writedata[FLAG_ILLEGAL_BIT]) begin
            illegal_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   property p_acc_int_load;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && op.to_acc && !op.illegal && !op.acc_b && core_control_reg[CTRL_INT_BIT])
      |=> (accumulator_a == {8'h00, $past(product)});
   endproperty
   a_acc_int_load: assert property (p_acc_int_load) else $error("accumulator A not loaded with product");

   property p_acc_zero_fill;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && op.to_acc && !op.illegal) |=> (accumulator_a[39:32] == 8'h00) && (accumulator_b[39:32] == 8'h00);
   endproperty
   a_acc_zero_fill: assert property (p_acc_zero_fill) else $error("accumulator upper bits not zero");

   property p_lit_unsigned;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && op.to_acc) |-> (product == 32'(wreg[op.base] * {11'h000, op.lit}));
   endproperty
   a_lit_unsigned: assert property (p_lit_unsigned) else $error("literal product not unsigned");

   property p_acc_frac_load;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && op.to_acc && !op.illegal && op.acc_b && !core_control_reg[CTRL_INT_BIT])
      |=> (accumulator_b == {7'h00, $past(product), 1'b0});
   endproperty
   a_acc_frac_load: assert property (p_acc_frac_load) else $error("fraction scaling wrong");

   property p_other_acc_kept;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && op.to_acc && !op.acc_b) |=> $stable(accumulator_b);
   endproperty
   a_other_acc_kept: assert property (p_other_acc_kept) else $error("wrong accumulator written");

   property p_dest_legal;
      @(posedge mclk) disable iff (!rst_s_n)
      word_wb |-> (!op.dst[0] && (op.dst <= DEST_MAX));
   endproperty
   a_dest_legal: assert property (p_dest_legal) else $error("illegal destination written");

   property p_post_inc;
      @(posedge mclk) disable iff (!rst_s_n)
      (exec && !op.illegal && !op.use_lit && (op.mode == AM_POST_INC) && (op.to_acc || op.src != op.dst))
      |=> (wreg[$past(op.src)] == $past(src_ptr) + ADDR_STEP);
   endproperty
   a_post_inc: assert property (p_post_inc) else $error("post-increment pointer wrong");

   property p_word_result;
      @(posedge mclk) disable iff (!rst_s_n)
      word_wb |=> (wreg[$past(op.dst)] == $past(product[15:0]));
   endproperty
   a_word_result: assert property (p_word_result) else $error("word result not stored");

   property p_status_kept;
      @(posedge mclk) disable iff (!rst_s_n)
      launch |=> ##1 $stable(status_reg);
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("status changed by multiply");

   property p_bus_answer;
      @(posedge mclk) disable iff (!rst_s_n)
      (avs_read && avs_waitrequest && !busy) |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
endmodule : wmu_top

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the word multiply unit over its Avalon-MM slave port
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import wmu_pkg::*;

   // ------------------------------------------------------------------------
   // Clock, reset and bus signals
   // ------------------------------------------------------------------------
   logic mclk;
   logic rst_n;
   logic [WMU_ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int failures;
   int check_count;
   int cycles;
   int i;
   logic [3:0] dsts [3];
   logic [7:0] opcs [3];
   logic forms [3];
   logic [15:0] w1_exp [6];
   logic [15:0] res_exp [6];
   logic [23:0] bad_ops [4];

   wmu_top #(.DMEM_DEPTH(32)) dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   // 40 MHz clock
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // ------------------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------------------
   // Ends the run with counts and verdict
   task automatic summarize();
      $display("Checks made: %0d, mismatches: %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   // Write held until the edge that sees waitrequest low
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : wr

   // Read data taken at the edge that sees waitrequest low
   task automatic rd(input logic [9:0] a, output logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rdchk(input string what, input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask : rdchk

   function automatic logic [9:0] wreg(input int n);
      return OFS_WREG_BASE + 10'(n * 4);
   endfunction : wreg

   // Launches one instruction word
   task automatic exec(input logic [23:0] iw);
      wr(OFS_INSTR, {8'h00, iw});
   endtask : exec

   function automatic logic [23:0] lit_acc(input logic [3:0] w, input logic acc_b, input logic [4:0] k);
      return {OPC_GRP_B8, 1'b0, w, ACC_FORM_D, acc_b, LIT_FORM_P, k};
   endfunction : lit_acc

   function automatic logic [23:0] word_op(input logic [7:0] opc, input logic form, input logic [3:0] w,
                                           input logic [3:0] d, input logic [2:0] p, input logic [3:0] s);
      return {opc, form, w, d, p, s};
   endfunction : word_op

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("Error timeout: expected completion, seen hang");
         summarize();
      end
   end

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      failures = 0;
      check_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(posedge mclk);

      // Reset values, read-only and unmapped places
      rdchk("core_ctrl", OFS_CORE_CTRL, 32'h0000_0001);
      rdchk("flags", OFS_FLAGS, 32'h0000_0000);
      wr(OFS_STATUS, 32'h0000_00A5);
      wr(OFS_ACCUMULATOR_A_LO, 32'h0000_1234);
      rdchk("accumulator_a_lo", OFS_ACCUMULATOR_A_LO, 32'h0000_0000);
      wr(10'h3FC, 32'h0000_5555);
      rdchk("unmapped", 10'h3FC, 32'h0000_0000);
      $display("Test reset values done");

      // Literal multiply, integer mode, largest, small and zero operands
      wr(wreg(3), 32'h0000_FFFF);
      wr(wreg(8), 32'h0000_0042);
      exec(lit_acc(4'h3, 1'b0, 5'h1F));
      rdchk("accumulator_a_lo", OFS_ACCUMULATOR_A_LO, 32'h0000_FFE1);
      rdchk("accumulator_a_hi", OFS_ACCUMULATOR_A_HI, 32'h0000_001E);
      rdchk("accumulator_a_up", OFS_ACCUMULATOR_A_UP, 32'h0000_0000);
      exec(lit_acc(4'h8, 1'b1, 5'h02));
      rdchk("accumulator_b_lo", OFS_ACCUMULATOR_B_LO, 32'h0000_0084);
      rdchk("accumulator_b_hi", OFS_ACCUMULATOR_B_HI, 32'h0000_0000);
      rdchk("accumulator_a_lo", OFS_ACCUMULATOR_A_LO, 32'h0000_FFE1);
      exec(lit_acc(4'h8, 1'b1, 5'h00));
      rdchk("accumulator_b_lo", OFS_ACCUMULATOR_B_LO, 32'h0000_0000);
      $display("Test literal integer done");

      // Fraction mode with sign mode bits set
      wr(OFS_CORE_CTRL, 32'h0000_0006);
      rdchk("core_ctrl", OFS_CORE_CTRL, 32'h0000_0006);
      exec(lit_acc(4'h3, 1'b1, 5'h1F));
      rdchk("accumulator_b_lo", OFS_ACCUMULATOR_B_LO, 32'h0000_FFC2);
      rdchk("accumulator_b_hi", OFS_ACCUMULATOR_B_HI, 32'h0000_003D);
      rdchk("accumulator_b_up", OFS_ACCUMULATOR_B_UP, 32'h0000_0000);
      $display("Test literal fraction done");

      // Word forms, direct source, negative base
      opcs = '{OPC_GRP_B9, OPC_GRP_B9, OPC_GRP_B8};
      forms = '{1'b1, 1'b0, 1'b1};
      dsts = '{4'h2, 4'hA, 4'hC};
      wr(wreg(5), 32'h0000_FFFE);
      wr(wreg(6), 32'h0000_0003);
      for (i = 0; i < 3; i++) begin
         exec(word_op(opcs[i], forms[i], 4'h5, dsts[i], AM_DIRECT, 4'h6));
         rdchk("word_result", wreg(int'(dsts[i])), 32'h0000_FFFA);
      end
      exec({OPC_GRP_B9, 1'b0, 4'h5, 4'h0, LIT_FORM_P, 5'h05});
      rdchk("su_literal", wreg(0), 32'h0000_FFF6);
      rdchk("status", OFS_STATUS, 32'h0000_00A5);
      $display("Test word direct done");

      // Indirect source modes with pointer updates
      wr(OFS_DMEM_BASE + 10'h004, 32'h0000_0011);
      wr(OFS_DMEM_BASE + 10'h008, 32'h0000_0068);
      wr(OFS_DMEM_BASE + 10'h00C, 32'h0000_0100);
      wr(wreg(2), 32'h0000_0040);
      w1_exp = '{16'h0004, 16'h0004, 16'h0002, 16'h0006, 16'h0002, 16'h0006};
      res_exp = '{16'h0100, 16'h1A00, 16'h1A00, 16'h1A00, 16'h0440, 16'h4000};
      for (i = 1; i < 6; i++) begin
         wr(wreg(1), 32'h0000_0004);
         exec(word_op(OPC_GRP_B9, 1'b1, 4'h2, 4'h4, 3'(i), 4'h1));
         rdchk("indirect_result", wreg(4), {16'h0000, res_exp[i]});
         rdchk("pointer", wreg(1), {16'h0000, w1_exp[i]});
      end
      $display("Test indirect modes done");

      // Refused encodings set the sticky flag and write nothing
      bad_ops = '{word_op(OPC_GRP_B9, 1'b1, 4'h5, 4'hE, AM_DIRECT, 4'h6),
                  word_op(OPC_GRP_B9, 1'b1, 4'h5, 4'h3, AM_DIRECT, 4'h6),
                  word_op(OPC_GRP_B9, 1'b1, 4'h5, 4'h4, 3'h6, 4'h6),
                  word_op(OPC_GRP_B8, 1'b0, 4'h5, 4'h0, AM_DIRECT, 4'h6)};
      for (i = 0; i < 4; i++) begin
         exec(bad_ops[i]);
         rdchk("flags_bad", OFS_FLAGS, 32'h0000_0002);
         wr(OFS_FLAGS, 32'h0000_0002);
         rdchk("flags_clear", OFS_FLAGS, 32'h0000_0000);
      end
      rdchk("reg_fourteen", wreg(14), 32'h0000_0000);
      rdchk("reg_three", wreg(3), 32'h0000_FFFF);
      rdchk("reg_four", wreg(4), 32'h0000_4000);
      rdchk("status", OFS_STATUS, 32'h0000_00A5);
      $display("Test refused encodings done");

      // Partial lanes: low byte only, then an instruction word with lane 2 off
      avs_byteenable <= 4'h1;
      wr(wreg(7), 32'h0000_ABCD);
      rdchk("lane_low", wreg(7), 32'h0000_00CD);
      avs_byteenable <= 4'h3;
      exec(lit_acc(4'h3, 1'b1, 5'h01));
      avs_byteenable <= 4'hF;
      rdchk("no_launch", OFS_ACCUMULATOR_B_LO, 32'h0000_FFC2);
      rdchk("flags_quiet", OFS_FLAGS, 32'h0000_0000);
      $display("Test byte lanes done");
      summarize();
   end
endmodule : testbench

`default_nettype wire
